// ### verilog/mie_exec.sv
// execute core for a subset of the single-word instructions, wishbone slave
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns

// Functional notes
// - bit clear forces R<b> low, flags kept
// - bit set forces R<b> high, flags kept
// - skip next when tested bit is zero
// - skip next when tested bit is one
// - skipped instruction becomes nop, single cycle
// - call pushes pc+1, loads buffer bit, immediate
// - goto loads buffer bit and immediate, two cycles
// - clear work register, set zero flag
// - clear file register, set zero flag
// - kick zeroes watchdog, prescaler if assigned, sets flags
// - invert register into chosen destination, update zero
// - decimal fix after sum, update carry
// - decimal fix after difference, no flags
// - count up or down, route, update zero
// - count down into destination, skip on zero
// - count up into destination, skip on zero
// - trap pushes pc+1, jumps to vector two
// - or work with file into destination, zero
// - or immediate into work, update zero
// - load direction register five or six
module mie_exec
  import mie_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [7:0]  dir_a_o,
  output logic      [7:0]  dir_b_o
);

  mie_stack_if st_if ();

  mie_state_t      state;
  logic            ack;
  logic            skip_pending;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] pc_plus1;
  logic [7:0]      work;
  logic [7:0]      file_mem [FILE_DEPTH];
  logic            z_flag;
  logic            dc_flag;
  logic            c_flag;
  logic            to_flag;
  logic            pd_flag;
  logic [7:0]      pc_high_buf;
  logic [1:0]      ctrl;
  logic [7:0]      wdt;
  logic [7:0]      presc;
  logic [7:0]      dir_a;
  logic [7:0]      dir_b;

  logic            req;
  logic            bus_wr;
  logic            do_exec;
  logic            do_real;
  mie_op_t         cur_op;
  logic [5:0]      cur_r;
  logic [2:0]      cur_b;
  logic            cur_d;
  logic [9:0]      cur_imm;
  logic [7:0]      imm8;
  logic [7:0]      src;
  logic            sel_bit;
  logic [7:0]      alu_res;
  logic            alu_writes;
  logic            alu_sets_z;
  logic            alu_skips;
  logic [8:0]      daa_res;
  logic [7:0]      das_res;
  logic            wdt_tick;
  logic            wdt_wrap;
  logic [5:0]      file_idx;

  // file registers sit one per word in their own page
  function automatic logic is_file_adr(input logic [11:0] a);
    return a[11:8] == ADR_FILE_PAGE;
  endfunction

  // bcd adjust after add: low then high correction, carry out
  function automatic logic [8:0] dec_fix_sum(input logic [7:0] v, input logic dc,
                                              input logic c);
    logic [8:0] t;
    t = {1'b0, v};
    if (dc || (v[3:0] > 4'h9)) begin
      t = t + 9'h006;
    end
    if (c || t[8] || (t[7:4] > 4'h9)) begin
      t = t + 9'h060;
      t[8] = 1'b1;
    end
    return t;
  endfunction

  // bcd adjust after subtract: flags mean no borrow when set
  function automatic logic [7:0] dec_fix_diff(input logic [7:0] v, input logic dc,
                                               input logic c);
    logic [7:0] t;
    t = v;
    if (!dc) begin
      t = t - 8'h06;
    end
    if (!c) begin
      t = t - 8'h60;
    end
    return t;
  endfunction

  // request decode; a command only executes once per bus cycle
  assign req      = wb_cyc_i && wb_stb_i;
  assign bus_wr   = req && wb_we_i && !ack && (state == st_idle);
  assign do_exec  = bus_wr && (wb_adr_i == ADR_CMD) && (wb_sel_i == 4'hf);
  assign do_real  = do_exec && !skip_pending;
  assign cur_op   = mie_op_t'(wb_dat_i[CMD_OP_LSB +: 5]);
  assign cur_r    = wb_dat_i[CMD_R_LSB +: 6];
  assign cur_b    = wb_dat_i[CMD_B_LSB +: 3];
  assign cur_d    = wb_dat_i[CMD_D_POS];
  assign cur_imm  = wb_dat_i[CMD_IMM_LSB +: 10];
  assign imm8     = cur_imm[7:0];
  assign src      = file_mem[cur_r];
  assign sel_bit  = src[cur_b];
  assign pc_plus1 = pc + 1'b1;
  assign daa_res  = dec_fix_sum(work, dc_flag, c_flag);
  assign das_res  = dec_fix_diff(work, dc_flag, c_flag);
  assign file_idx = wb_adr_i[7:2];

  // shared result path for the destination-routed instructions
  always_comb begin
    alu_res    = src;
    alu_writes = 1'b1;
    alu_sets_z = 1'b1;
    alu_skips  = 1'b0;
    case (cur_op)
      invert_file_reg:      alu_res = ~src;
      count_down_op:        alu_res = src - 8'h01;
      count_up_op:          alu_res = src + 8'h01;
      or_with_file_reg:     alu_res = work | src;
      count_down_skip_zero: begin
        alu_res    = src - 8'h01;
        alu_sets_z = 1'b0;
        alu_skips  = 1'b1;
      end
      count_up_skip_zero: begin
        alu_res    = src + 8'h01;
        alu_sets_z = 1'b0;
        alu_skips  = 1'b1;
      end
      default: begin
        alu_writes = 1'b0;
        alu_sets_z = 1'b0;
      end
    endcase
  end

  // bus handshake; branch-type commands hold ack back one extra cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state <= st_idle;
      ack   <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          if (req && !ack && do_real &&
              (cur_op == call_op || cur_op == goto_op || cur_op == trap_op)) begin
            state <= st_second;
            ack   <= 1'b0;
          end else begin
            ack <= req && !ack;
          end
        end
        st_second: begin
          state <= st_idle;
          ack   <= 1'b1;
        end
        default: begin
          state <= st_idle;
          ack   <= 1'b0;
        end
      endcase
    end
  end
  assign wb_ack_o = ack;

  // a taken skip turns the next command into a nop
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      skip_pending <= 1'b0;
    end else if (do_exec) begin
      if (skip_pending) begin
        skip_pending <= 1'b0;
      end else if (cur_op == test_skip_if_zero) begin
        skip_pending <= !sel_bit;
      end else if (cur_op == test_skip_if_one) begin
        skip_pending <= sel_bit;
      end else begin
        skip_pending <= alu_skips && (alu_res == 8'h00);
      end
    end
  end

  // program counter; software may also load it directly
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pc <= RST_PC;
    end else if (do_real && (cur_op == call_op || cur_op == goto_op)) begin
      pc <= {pc_high_buf[PCH_BIT], cur_imm};
    end else if (do_real && cur_op == trap_op) begin
      pc <= TRAP_VECTOR;
    end else if (do_exec) begin
      pc <= pc_plus1;
    end else if (bus_wr && wb_adr_i == ADR_PC && wb_sel_i[0] && wb_sel_i[1]) begin
      pc <= wb_dat_i[PC_W-1:0];
    end
  end

  // return address push happens in the first cycle of call and trap
  assign st_if.push      = do_real && (cur_op == call_op || cur_op == trap_op);
  assign st_if.push_addr = pc_plus1;

  // work register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      work <= RST_BYTE;
    end else if (do_real) begin
      case (cur_op)
        clear_work_register:    work <= 8'h00;
        decimal_fix_after_sum:  work <= daa_res[7:0];
        decimal_fix_after_diff: work <= das_res;
        or_with_immediate:      work <= work | imm8;
        default: begin
          if (alu_writes && !cur_d) begin
            work <= alu_res;
          end
        end
      endcase
    end else if (bus_wr && wb_adr_i == ADR_WORK && wb_sel_i[0]) begin
      work <= wb_dat_i[7:0];
    end
  end

  // file registers: bit ops, clear and routed results
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_mem[i] <= RST_BYTE;
      end
    end else if (do_real) begin
      if (cur_op == bit_clear_op) begin
        file_mem[cur_r][cur_b] <= 1'b0;
      end else if (cur_op == bit_set_op) begin
        file_mem[cur_r][cur_b] <= 1'b1;
      end else if (cur_op == clear_file_reg) begin
        file_mem[cur_r] <= 8'h00;
      end else if (alu_writes && cur_d) begin
        file_mem[cur_r] <= alu_res;
      end
    end else if (bus_wr && is_file_adr(wb_adr_i) && wb_sel_i[0]) begin
      file_mem[file_idx] <= wb_dat_i[7:0];
    end
  end

  // arithmetic flags
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      z_flag  <= 1'b0;
      dc_flag <= 1'b0;
      c_flag  <= 1'b0;
    end else if (do_real) begin
      if (cur_op == clear_work_register || cur_op == clear_file_reg) begin
        z_flag <= 1'b1;
      end else if (cur_op == or_with_immediate) begin
        z_flag <= (work | imm8) == 8'h00;
      end else if (cur_op == decimal_fix_after_sum) begin
        c_flag <= daa_res[8];
      end else if (alu_sets_z) begin
        z_flag <= alu_res == 8'h00;
      end
    end else if (bus_wr && wb_adr_i == ADR_STATUS && wb_sel_i[0]) begin
      z_flag  <= wb_dat_i[ST_Z];
      dc_flag <= wb_dat_i[ST_DC];
      c_flag  <= wb_dat_i[ST_C];
    end
  end

  // time-out and power-down; a watchdog wrap beats a software write
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      to_flag <= RST_TO;
      pd_flag <= RST_PD;
    end else if (do_real && cur_op == watchdog_kick) begin
      to_flag <= 1'b1;
      pd_flag <= 1'b1;
    end else if (wdt_wrap) begin
      to_flag <= 1'b0;
    end else if (bus_wr && wb_adr_i == ADR_STATUS && wb_sel_i[0]) begin
      to_flag <= wb_dat_i[ST_TO];
      pd_flag <= wb_dat_i[ST_PD];
    end
  end

  // watchdog; when the prescaler is not ours it stays with the timer
  assign wdt_tick = ctrl[CTRL_WDT_EN] && (!ctrl[CTRL_PRESC_WDT] || presc == 8'hff);
  assign wdt_wrap = wdt_tick && (wdt == 8'hff);
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wdt   <= RST_BYTE;
      presc <= RST_BYTE;
    end else if (do_real && cur_op == watchdog_kick) begin
      wdt <= 8'h00;
      if (ctrl[CTRL_PRESC_WDT]) begin
        presc <= 8'h00;
      end else begin
        presc <= presc + 8'h01;
      end
    end else begin
      presc <= presc + 8'h01;
      if (wdt_tick) begin
        wdt <= wdt + 8'h01;
      end
    end
  end

  // software-only registers and the two port direction registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pc_high_buf <= RST_BYTE;
      ctrl   <= RST_CTRL;
      dir_a  <= RST_BYTE;
      dir_b  <= RST_BYTE;
    end else if (do_real && cur_op == port_direction_load) begin
      if (cur_r == DIR_A_IDX) begin
        dir_a <= work;
      end else if (cur_r == DIR_B_IDX) begin
        dir_b <= work;
      end
    end else if (bus_wr && wb_sel_i[0]) begin
      if (wb_adr_i == ADR_PC_HIGH) begin
        pc_high_buf <= wb_dat_i[7:0];
      end else if (wb_adr_i == ADR_CTRL) begin
        ctrl <= wb_dat_i[1:0];
      end
    end
  end
  assign dir_a_o = dir_a;
  assign dir_b_o = dir_b;

  // read data; unmapped and command reads return zero
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      if (wb_adr_i == ADR_WORK) begin
        wb_dat_o <= {24'h000000, work};
      end else if (wb_adr_i == ADR_STATUS) begin
        wb_dat_o <= {26'h0, skip_pending, to_flag, pd_flag, c_flag, dc_flag, z_flag};
      end else if (wb_adr_i == ADR_PC) begin
        wb_dat_o <= {21'h0, pc};
      end else if (wb_adr_i == ADR_PC_HIGH) begin
        wb_dat_o <= {24'h000000, pc_high_buf};
      end else if (wb_adr_i == ADR_CTRL) begin
        wb_dat_o <= {30'h0, ctrl};
      end else if (wb_adr_i == ADR_WDT) begin
        wb_dat_o <= {24'h000000, wdt};
      end else if (wb_adr_i == ADR_PRESC) begin
        wb_dat_o <= {24'h000000, presc};
      end else if (wb_adr_i == ADR_DIR_A) begin
        wb_dat_o <= {24'h000000, dir_a};
      end else if (wb_adr_i == ADR_DIR_B) begin
        wb_dat_o <= {24'h000000, dir_b};
      end else if (wb_adr_i == ADR_STACK_TOP) begin
        wb_dat_o <= {21'h0, st_if.top};
      end else if (is_file_adr(wb_adr_i)) begin
        wb_dat_o <= {24'h000000, file_mem[file_idx]};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  mie_stack #(
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .st        (st_if.stack)
  );

  a_bit_clear_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    do_real && cur_op == bit_clear_op |=>
      !file_mem[$past(cur_r)][$past(cur_b)] && $stable({z_flag, c_flag, dc_flag}))
    else $error("bit clear did not clear the bit or touched flags");

  a_bit_set_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    do_real && cur_op == bit_set_op |=>
      file_mem[$past(cur_r)][$past(cur_b)] && $stable({z_flag, c_flag, dc_flag}))
    else $error("bit set did not set the bit or touched flags");

  a_test_skip_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    do_real && cur_op == test_skip_if_zero |=> skip_pending == !$past(sel_bit))
    else $error("skip-if-zero decided wrongly");

  a_test_skip_one: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    do_real && cur_op == test_skip_if_one |=> skip_pending == $past(sel_bit))
    else $error("skip-if-one decided wrongly");

  a_skip_as_nop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    do_exec && skip_pending |=>
      $stable(work) && $stable(z_flag) && !skip_pending && pc == $past(pc_plus1))
    else $error("discarded command was not a nop");

  a_call_target: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    do_real && cur_op == call_op |=>
      pc == {$past(pc_high_buf[PCH_BIT]), $past(cur_imm)} && st_if.top == $past(pc_plus1)
      && !wb_ack_o ##1 wb_ack_o)
    else $error("call target, push or timing wrong");

  a_goto_two_cycle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    do_real && cur_op == goto_op |=> !wb_ack_o ##1 wb_ack_o && $stable(z_flag))
    else $error("goto did not take two cycles");

  a_clear_sets_z: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    do_real && cur_op == clear_work_register |=> work == 8'h00 && z_flag && wb_ack_o)
    else $error("clear work register wrong");

  a_kick_flags: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    do_real && cur_op == watchdog_kick |=> wdt == 8'h00 && to_flag && pd_flag)
    else $error("watchdog kick left counter or flags wrong");

  a_count_skip: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    do_real && alu_skips |=> skip_pending == ($past(alu_res) == 8'h00) && $stable(z_flag))
    else $error("count-and-skip skip or flags wrong");

  a_trap_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    do_real && cur_op == trap_op |=> pc == TRAP_VECTOR && st_if.top == $past(pc_plus1))
    else $error("trap vector or push wrong");

  a_or_imm_work: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    do_real && cur_op == or_with_immediate |=>
      work == ($past(work) | $past(imm8)) && z_flag == (work == 8'h00))
    else $error("immediate or result or zero flag wrong");

endmodule // mie_exec

// ### verilog/mie_pkg.sv
// constants, field layout and types shared by the instruction execute block
package mie_pkg;

  // widths and depths
  localparam int unsigned PC_W        = 11;
  localparam int unsigned FILE_DEPTH  = 64;
  localparam int unsigned STACK_DEPTH = 5;

  // register byte offsets on the wishbone side
  localparam logic [11:0] ADR_CMD       = 12'h000;
  localparam logic [11:0] ADR_WORK      = 12'h004;
  localparam logic [11:0] ADR_STATUS    = 12'h008;
  localparam logic [11:0] ADR_PC        = 12'h00c;
  localparam logic [11:0] ADR_PC_HIGH   = 12'h010;
  localparam logic [11:0] ADR_CTRL      = 12'h014;
  localparam logic [11:0] ADR_WDT       = 12'h018;
  localparam logic [11:0] ADR_PRESC     = 12'h01c;
  localparam logic [11:0] ADR_DIR_A     = 12'h020;
  localparam logic [11:0] ADR_DIR_B     = 12'h024;
  localparam logic [11:0] ADR_STACK_TOP = 12'h028;
  localparam logic [3:0]  ADR_FILE_PAGE = 4'h1;   // 0x100..0x1fc, word per file register

  // command word fields
  localparam int unsigned CMD_R_LSB   = 0;
  localparam int unsigned CMD_B_LSB   = 6;
  localparam int unsigned CMD_D_POS   = 9;
  localparam int unsigned CMD_IMM_LSB = 16;
  localparam int unsigned CMD_OP_LSB  = 26;

  // status register bit positions
  localparam int unsigned ST_Z    = 0;
  localparam int unsigned ST_DC   = 1;
  localparam int unsigned ST_C    = 2;
  localparam int unsigned ST_PD   = 3;
  localparam int unsigned ST_TO   = 4;
  localparam int unsigned ST_SKIP = 5;

  // control register bit positions
  localparam int unsigned CTRL_PRESC_WDT = 0;
  localparam int unsigned CTRL_WDT_EN    = 1;

  // values after reset and fixed values
  localparam logic [1:0]      RST_CTRL    = 2'h2;
  localparam logic            RST_TO      = 1'b1;
  localparam logic            RST_PD      = 1'b1;
  localparam logic [7:0]      RST_BYTE    = 8'h00;
  localparam logic [PC_W-1:0] RST_PC      = 11'h000;
  localparam logic [PC_W-1:0] TRAP_VECTOR = 11'h002;
  localparam logic [5:0]      DIR_A_IDX   = 6'h05;
  localparam logic [5:0]      DIR_B_IDX   = 6'h06;
  localparam int unsigned     PCH_BIT     = 2;

  typedef enum logic [4:0] {
    nop_op                 = 5'h00,
    bit_clear_op           = 5'h01,
    bit_set_op             = 5'h02,
    test_skip_if_zero      = 5'h03,
    test_skip_if_one       = 5'h04,
    call_op                = 5'h05,
    goto_op                = 5'h06,
    trap_op                = 5'h07,
    clear_work_register    = 5'h08,
    clear_file_reg         = 5'h09,
    watchdog_kick          = 5'h0a,
    invert_file_reg        = 5'h0b,
    decimal_fix_after_sum  = 5'h0c,
    decimal_fix_after_diff = 5'h0d,
    count_down_op          = 5'h0e,
    count_up_op            = 5'h0f,
    count_down_skip_zero   = 5'h10,
    count_up_skip_zero     = 5'h11,
    or_with_file_reg       = 5'h12,
    or_with_immediate      = 5'h13,
    port_direction_load    = 5'h14
  } mie_op_t;

  typedef enum logic [0:0] {
    st_idle   = 1'b0,
    st_second = 1'b1
  } mie_state_t;

endpackage

// ### verilog/mie_stack_if.sv
// carrier between the execute core and the return stack
`timescale 1ns/1ns
interface mie_stack_if;
  import mie_pkg::*;
  logic            push;
  logic [PC_W-1:0] push_addr;
  logic [PC_W-1:0] top;
  modport core  (output push, output push_addr, input top);
  modport stack (input push, input push_addr, output top);
endinterface

// ### verilog/mie_stack.sv
// fixed-depth return stack; overflow overwrites the oldest entry
`timescale 1ns/1ns
module mie_stack
  import mie_pkg::*;
#(
  parameter int unsigned DEPTH = STACK_DEPTH
) (
  input  wire logic  sys_clk_i,
  input  wire logic  rst_n_i,
  mie_stack_if.stack st
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [PC_W-1:0] mem [DEPTH];
  logic [PW-1:0]   wr_ptr;
  logic [PW-1:0]   top_ptr;

  // circular pointer: no full check, oldest slot is simply reused
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
    end else if (st.push) begin
      wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
    end
  end

  // entry storage
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= RST_PC;
      end
    end else if (st.push) begin
      mem[wr_ptr] <= st.push_addr;
    end
  end

  assign top_ptr = (wr_ptr == '0) ? LAST : wr_ptr - 1'b1;
  assign st.top  = mem[top_ptr];

endmodule // mie_stack

// ### test/tb_mie_exec.sv
// self-checking bench for the instruction execute block
`timescale 1ns/1ns
module tb_mie_exec;
  import mie_pkg::*;
  typedef struct {mie_op_t op; logic [2:0] b; logic d; logic [9:0] im;
                  logic [7:0] fv, wv, ef, ew, es;} mie_row_t;
  logic        sys_clk_i;
  logic        rst_n_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic [3:0]  sel;
  logic [11:0] adr;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  logic [31:0] v;
  logic [7:0]  dir_a;
  logic [7:0]  dir_b;
  int          err_total;
  int          total_checks;
  int          n;
  mie_row_t    rows [18];

  mie_exec DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .dir_a_o(dir_a), .dir_b_o(dir_b));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; n counts edges up to the one that sees ack
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge sys_clk_i);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    sel   <= s;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    v = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) begin
      err_total++;
      results();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hff);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(v & m, e);
  endtask

  task automatic cmd(input mie_op_t op, input logic [5:0] r, input logic [2:0] b,
                     input logic d, input logic [9:0] im);
    wr(ADR_CMD, {1'b0, op, im, 6'h00, d, b, r});
  endtask

  initial begin
    rows = '{
      '{bit_clear_op,           3'h7, 1'b0, 10'h0,   8'hff, 8'h00, 8'h7f, 8'h00, 8'h18},
      '{bit_set_op,             3'h0, 1'b0, 10'h0,   8'h00, 8'h00, 8'h01, 8'h00, 8'h18},
      '{test_skip_if_zero,      3'h3, 1'b0, 10'h0,   8'hf7, 8'h00, 8'hf7, 8'h00, 8'h38},
      '{test_skip_if_zero,      3'h3, 1'b0, 10'h0,   8'h08, 8'h00, 8'h08, 8'h00, 8'h18},
      '{test_skip_if_one,       3'h3, 1'b0, 10'h0,   8'h08, 8'h00, 8'h08, 8'h00, 8'h38},
      '{clear_work_register,    3'h0, 1'b0, 10'h0,   8'h00, 8'h55, 8'h00, 8'h00, 8'h19},
      '{clear_file_reg,         3'h0, 1'b0, 10'h0,   8'h55, 8'h00, 8'h00, 8'h00, 8'h19},
      '{invert_file_reg,        3'h0, 1'b0, 10'h0,   8'h0f, 8'h00, 8'h0f, 8'hf0, 8'h18},
      '{invert_file_reg,        3'h0, 1'b1, 10'h0,   8'hff, 8'h00, 8'h00, 8'h00, 8'h19},
      '{count_down_op,          3'h0, 1'b1, 10'h0,   8'h01, 8'h00, 8'h00, 8'h00, 8'h19},
      '{count_up_op,            3'h0, 1'b0, 10'h0,   8'hff, 8'h11, 8'hff, 8'h00, 8'h19},
      '{count_down_skip_zero,   3'h0, 1'b1, 10'h0,   8'h01, 8'h00, 8'h00, 8'h00, 8'h38},
      '{count_up_skip_zero,     3'h0, 1'b0, 10'h0,   8'h05, 8'h00, 8'h05, 8'h06, 8'h18},
      '{or_with_file_reg,       3'h0, 1'b0, 10'h0,   8'h0f, 8'hf0, 8'h0f, 8'hff, 8'h18},
      '{or_with_immediate,      3'h0, 1'b0, 10'h081, 8'h00, 8'h10, 8'h00, 8'h91, 8'h18},
      '{decimal_fix_after_sum,  3'h0, 1'b0, 10'h0,   8'h00, 8'h1a, 8'h00, 8'h20, 8'h18},
      '{decimal_fix_after_sum,  3'h0, 1'b0, 10'h0,   8'h00, 8'ha0, 8'h00, 8'h00, 8'h1c},
      '{decimal_fix_after_diff, 3'h0, 1'b0, 10'h0,   8'h00, 8'h20, 8'h00, 8'hba, 8'h18}};
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    sel = 4'h0;
    dat_w = 32'h0;
    err_total = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    // values straight after reset
    rc(ADR_STATUS, 32'h18);
    rc(ADR_CTRL, 32'h2);
    chk(dir_a, 32'h0);
    // park the watchdog: a wrap every 256 cycles would clear the time-out bit mid-row
    wr(ADR_CTRL, 32'h0);
    // each row on file register 1; the trailing nop drains any pending skip
    foreach (rows[i]) begin
      wr(ADR_STATUS, 32'h18);
      wr(12'h104, {24'h0, rows[i].fv});
      wr(ADR_WORK, {24'h0, rows[i].wv});
      cmd(rows[i].op, 6'h01, rows[i].b, rows[i].d, rows[i].im);
      chk(n, 2);
      rc(12'h104, rows[i].ef);
      rc(ADR_WORK, rows[i].ew);
      rc(ADR_STATUS, rows[i].es);
      cmd(nop_op, 6'h00, 3'h0, 1'b0, 10'h0);
    end
    // a skip survives other bus traffic and turns a goto into a one-cycle nop
    wr(12'h104, 32'h00);
    cmd(test_skip_if_zero, 6'h01, 3'h0, 1'b0, 10'h0);
    rc(12'h040, 32'h0);
    wr(ADR_PC, 32'h020);
    cmd(goto_op, 6'h00, 3'h0, 1'b0, 10'h100);
    chk(n, 2);
    rc(ADR_PC, 32'h021, 32'h7ff);
    // branches: two cycles, high buffer bit 2 lands in pc bit 10
    wr(ADR_PC_HIGH, 32'h04);
    wr(ADR_PC, 32'h010);
    cmd(call_op, 6'h00, 3'h0, 1'b0, 10'h155);
    chk(n, 3);
    rc(ADR_PC, 32'h555, 32'h7ff);
    rc(ADR_STACK_TOP, 32'h011, 32'h7ff);
    wr(ADR_PC_HIGH, 32'h00);
    cmd(goto_op, 6'h00, 3'h0, 1'b0, 10'h3ff);
    chk(n, 3);
    rc(ADR_PC, 32'h3ff, 32'h7ff);
    cmd(trap_op, 6'h00, 3'h0, 1'b0, 10'h0);
    chk(n, 3);
    rc(ADR_PC, 32'h002, 32'h7ff);
    rc(ADR_STACK_TOP, 32'h400, 32'h7ff);
    rc(ADR_STATUS, 32'h18);
    // six pushes in all: the write pointer wraps, top still shows the newest entry
    repeat (4) cmd(trap_op, 6'h00, 3'h0, 1'b0, 10'h0);
    rc(ADR_STACK_TOP, 32'h003, 32'h7ff);
    // direction loads; a command with a partial lane select does nothing
    wr(ADR_WORK, 32'ha5);
    cmd(port_direction_load, 6'h05, 3'h0, 1'b0, 10'h0);
    wb(1'b1, ADR_CMD, {1'b0, clear_work_register, 26'h0}, 4'h3);
    rc(ADR_WORK, 32'ha5);
    wr(ADR_WORK, 32'h3c);
    cmd(port_direction_load, 6'h06, 3'h0, 1'b0, 10'h0);
    cmd(port_direction_load, 6'h07, 3'h0, 1'b0, 10'h0);
    chk(dir_a, 32'ha5);
    chk(dir_b, 32'h3c);
    // kick with the prescaler on the watchdog side
    wr(ADR_CTRL, 32'h3);
    wr(ADR_STATUS, 32'h00);
    cmd(watchdog_kick, 6'h00, 3'h0, 1'b0, 10'h0);
    rc(ADR_WDT, 32'h0);
    rc(ADR_STATUS, 32'h18);
    rc(ADR_PRESC, 32'h0, 32'hf0);
    results();
  end
endmodule // tb_mie_exec
